// ===== bench/hsr_properties.sv
// Port checker of the slot repeat sequencer
`timescale 1ns/1ns
`default_nettype none
`include "hsr_defines.svh"

module hsr_chk
    import hsr_pkg::*;
#(
    parameter logic [`HSR_TICK_W-1:0] WAIT_UNIT_CYCLES = `HSR_TICK_W'(`HSR_WAIT_UNIT_CYCLES)
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic play_done_i,
    input wire logic [7:0] rdata_o,
    input wire hsr_play_t play_o,
    input wire logic busy_o,
    input wire logic waiting_o,
    input wire logic [2:0] slot_idx_o
);
    logic [1:0][7:0] rep_reg;
    logic [2:0] idx_reg;
    logic [2:0] cnt_reg;
    logic [1:0] fld;
    // Repeat field of the slot that the counter belongs to
    assign fld = rep_reg[idx_reg[2]][2*idx_reg[1:0] +: 2];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rep_reg <= '0;
            idx_reg <= 3'h0;
            cnt_reg <= 3'h0;
        end else if (ce_i) begin
            if (wr_i && addr_i == `HSR_ADDR_REPEAT_LO) begin
                rep_reg[0] <= wdata_i;
            end
            if (wr_i && addr_i == `HSR_ADDR_REPEAT_HI) begin
                rep_reg[1] <= wdata_i;
            end
            idx_reg <= slot_idx_o;
            // A new slot or an idle sequencer restarts the play count
            if (slot_idx_o != idx_reg || !busy_o) begin
                cnt_reg <= 3'h0;
            end else if (play_done_i && play_o.req) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_go;
        ce_i && wr_i && addr_i == `HSR_ADDR_CTRL && wdata_i[0] && !busy_o;
    endsequence
    sequence s_done;
        ce_i && play_o.req && play_done_i;
    endsequence

    go_starts_run_a: assert property (s_go |=> busy_o && slot_idx_o == 3'h0)
        else $error("run did not start at first slot");
    done_drops_req_a: assert property (s_done |=> !play_o.req)
        else $error("request held after done");
    req_holds_a: assert property (ce_i && play_o.req && !play_done_i && !wr_i |=> play_o.req)
        else $error("request dropped early");
    id_stable_a: assert property (play_o.req && $past(play_o.req) |-> $stable(play_o.effect_id))
        else $error("effect changed during request");
    repeat_total_a: assert property (busy_o && slot_idx_o != idx_reg && cnt_reg != 3'h0 |-> cnt_reg == {1'b0, fld} + 3'h1)
        else $error("slot left after wrong play count");
    repeat_bound_a: assert property (busy_o |-> cnt_reg <= {1'b0, fld} + 3'h1)
        else $error("slot played too often");
    resume_bound_a: assert property (s_done |-> ##[1:4] (play_o.req || waiting_o || !busy_o))
        else $error("no next effect after done");
    read_lo_a: assert property (ce_i && rd_i && addr_i == `HSR_ADDR_REPEAT_LO |=> rdata_o == rep_reg[0])
        else $error("low repeat register read wrong");
    read_hi_a: assert property (ce_i && rd_i && addr_i == `HSR_ADDR_REPEAT_HI |=> rdata_o == rep_reg[1])
        else $error("high repeat register read wrong");
    delay_no_req_a: assert property (waiting_o |-> !play_o.req)
        else $error("request during idle slot");
endmodule : hsr_chk

bind hsr_sequencer hsr_chk #(.WAIT_UNIT_CYCLES(WAIT_UNIT_CYCLES)) chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .play_done_i(play_done_i), .rdata_o(rdata_o), .play_o(play_o),
    .busy_o(busy_o), .waiting_o(waiting_o), .slot_idx_o(slot_idx_o));
`default_nettype wire

// ===== bench/test_haptic_sequence_slot_repeat.sv
// Self-checking bench of the slot repeat sequencer
`timescale 1ns/1ns
`default_nettype none
`include "hsr_defines.svh"

module test_haptic_sequence_slot_repeat
    import hsr_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic play_done_i = 1'b0;
    logic [7:0] rdata_o;
    hsr_play_t play_o;
    logic busy_o;
    logic waiting_o;
    logic [2:0] slot_idx_o;
    int bad_count = 0;
    int total_checks = 0;

    always #4 clk_i = ~clk_i;

    hsr_sequencer #(.WAIT_UNIT_CYCLES(21'h4)) dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .play_done_i(play_done_i), .rdata_o(rdata_o), .play_o(play_o),
        .busy_o(busy_o), .waiting_o(waiting_o), .slot_idx_o(slot_idx_o));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask : rd

    // Act as playback engine for one effect
    task automatic serve(input logic [6:0] id, input logic [2:0] idx);
        int n;
        n = 0;
        while (play_o.req !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check({7'h00, play_o.req}, 8'h01);
        check({1'b0, play_o.effect_id}, {1'b0, id});
        check({5'h00, slot_idx_o}, {5'h00, idx});
        repeat (2) @(posedge clk_i);
        play_done_i <= 1'b1;
        @(posedge clk_i);
        play_done_i <= 1'b0;
        #1;
        check({7'h00, play_o.req}, 8'h00);
    endtask : serve

    task automatic end_run();
        repeat (3) @(posedge clk_i);
        #1;
        check({7'h00, busy_o}, 8'h00);
    endtask : end_run

    task automatic regs_test();
        rd(`HSR_ADDR_REPEAT_LO, `HSR_REPEAT_RESET);
        rd(`HSR_ADDR_REPEAT_HI, `HSR_REPEAT_RESET);
        wr(`HSR_ADDR_REPEAT_LO, 8'hE4);
        wr(`HSR_ADDR_REPEAT_HI, 8'h1B);
        rd(`HSR_ADDR_REPEAT_LO, 8'hE4);
        rd(`HSR_ADDR_REPEAT_HI, 8'h1B);
        rd(8'h1F, 8'h00);
    endtask : regs_test

    // Slots 1 to 4 carry repeat fields 0 to 3, slot 5 stops
    task automatic repeat_test();
        for (int s = 0; s < 5; s++) begin
            wr(`HSR_ADDR_SLOT_FIRST + 8'(s), (s < 4) ? 8'h11 + 8'(s) : 8'h00);
        end
        wr(`HSR_ADDR_CTRL, 8'h01);
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k <= s; k++) begin
                serve(7'h11 + 7'(s), 3'(s));
            end
        end
        end_run();
    endtask : repeat_test

    // Repeated idle slot first, then the seven other slots with fields from both repeat registers
    task automatic delay_test();
        logic [15:0] rv;
        int n;
        int w;
        rv = 16'hC601;
        wr(`HSR_ADDR_SLOT_FIRST, 8'h81);
        for (int s = 1; s < 8; s++) begin
            wr(`HSR_ADDR_SLOT_FIRST + 8'(s), 8'h31 + 8'(s));
        end
        wr(`HSR_ADDR_REPEAT_LO, rv[7:0]);
        wr(`HSR_ADDR_REPEAT_HI, rv[15:8]);
        wr(`HSR_ADDR_CTRL, 8'h01);
        n = 0;
        w = 0;
        while (play_o.req !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
            if (waiting_o === 1'b1) begin
                w++;
            end
        end
        check(8'(w >= 8), 8'h01);
        for (int s = 1; s < 8; s++) begin
            for (int k = 0; k <= int'(rv[2*s +: 2]); k++) begin
                serve(7'h31 + 7'(s), 3'(s));
            end
        end
        end_run();
    endtask : delay_test

    // Clearing the go bit in an idle slot stops the run at once
    task automatic abort_test();
        wr(`HSR_ADDR_SLOT_FIRST, 8'h85);
        rd(`HSR_ADDR_SLOT_FIRST, 8'h85);
        wr(`HSR_ADDR_CTRL, 8'h01);
        rd(`HSR_ADDR_CTRL, 8'h01);
        check({7'h00, waiting_o}, 8'h01);
        wr(`HSR_ADDR_CTRL, 8'h00);
        rd(`HSR_ADDR_CTRL, 8'h00);
        check({7'h00, waiting_o}, 8'h00);
    endtask : abort_test

    // A write while the clock enable is low must not land
    task automatic freeze_test();
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(`HSR_ADDR_REPEAT_LO, 8'hFF);
        ce_i <= 1'b1;
        rd(`HSR_ADDR_REPEAT_LO, 8'h01);
    endtask : freeze_test

    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        regs_test();
        repeat_test();
        delay_test();
        abort_test();
        freeze_test();
        conclude();
    end

    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : test_haptic_sequence_slot_repeat
`default_nettype wire

// ===== hw/hsr_delay_timer.sv
// Idle-period timer counting whole units of the wait period
`timescale 1ns/1ns
`default_nettype none
`include "hsr_defines.svh"

module hsr_delay_timer
    import hsr_pkg::*;
#(
    parameter logic [`HSR_TICK_W-1:0] UNIT_CYCLES = `HSR_TICK_W'(`HSR_WAIT_UNIT_CYCLES)
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [6:0] units_i,
    output logic done_o
);
    hsr_tmr_t s_reg;
    hsr_tmr_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (abort_i) begin
            s_next.active = 1'b0;
        end else if (start_i) begin
            s_next.active = 1'b1;
            s_next.units_left = units_i;
            s_next.tick = '0;
        end else if (s_reg.active) begin
            if (s_reg.units_left == 7'h00) begin
                s_next.active = 1'b0;
                s_next.done = 1'b1;
            end else if (s_reg.tick == UNIT_CYCLES - `HSR_TICK_W'(1)) begin
                s_next.tick = '0;
                s_next.units_left = s_reg.units_left - 7'h01;
            end else begin
                s_next.tick = s_reg.tick + `HSR_TICK_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign done_o = s_reg.done;

endmodule : hsr_delay_timer
`default_nettype wire

// ===== hw/hsr_repeat_counter.sv
// Per-slot repeat counter compared against the slot's repeat field
`timescale 1ns/1ns
`default_nettype none
`include "hsr_defines.svh"

module hsr_repeat_counter
    import hsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic [`HSR_REPEAT_W-1:0] limit_i,
    output logic last_o
);
    hsr_rep_t s_reg;
    hsr_rep_t s_next;

    always_comb begin
        s_next = s_reg;
        if (clear_i) begin
            s_next.cnt = '0;
        end else if (step_i) begin
            s_next.cnt = s_reg.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign last_o = (s_reg.cnt == limit_i);

endmodule : hsr_repeat_counter
`default_nettype wire

// ===== hw/hsr_sequencer.sv
// Eight-slot haptic sequencer with per-slot repeat counts and its register port
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "hsr_defines.svh"

module hsr_sequencer
    import hsr_pkg::*;
#(
    parameter logic [`HSR_TICK_W-1:0] WAIT_UNIT_CYCLES = `HSR_TICK_W'(`HSR_WAIT_UNIT_CYCLES)
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic play_done_i,
    output logic [7:0] rdata_o,
    output hsr_play_t play_o,
    output logic busy_o,
    output logic waiting_o,
    output logic [2:0] slot_idx_o
);

    hsr_seq_t s_reg;
    hsr_seq_t s_next;

    // Handshake with the timer and the repeat counter
    logic tmr_start;
    logic tmr_abort;
    logic tmr_done;
    logic rep_clear;
    logic rep_step;
    logic rep_last;

    // Decoded register accesses
    logic go_set;
    logic go_clr;
    logic slot_hit;
    logic [7:0] slot_off;

    // Current slot and its repeat field
    hsr_slot_t cur_slot;
    logic [1:0] cur_repeat;
    logic effect_fin;

    // Repeat field of one slot: low register for slots 1-4, high for 5-8
    function automatic logic [1:0] slot_repeat_count(
        input logic [1:0][7:0] rpt,
        input logic [2:0] idx
    );
        logic [7:0] byte_sel;
        byte_sel = rpt[idx[2]];
        slot_repeat_count = byte_sel[{idx[1:0], 1'b0} +: 2];
    endfunction : slot_repeat_count

    hsr_delay_timer #(
        .UNIT_CYCLES(WAIT_UNIT_CYCLES)
    ) u_delay_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .start_i(tmr_start),
        .abort_i(tmr_abort),
        .units_i(cur_slot.effect_value),
        .done_o(tmr_done)
    );

    hsr_repeat_counter u_repeat_counter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .clear_i(rep_clear),
        .step_i(rep_step),
        .limit_i(cur_repeat),
        .last_o(rep_last)
    );

    always_comb begin
        slot_off = addr_i - `HSR_ADDR_SLOT_FIRST;
        slot_hit = (addr_i >= `HSR_ADDR_SLOT_FIRST) && (addr_i <= `HSR_ADDR_SLOT_LAST);
        go_set = wr_i && (addr_i == `HSR_ADDR_CTRL) && wdata_i[`HSR_CTRL_GO_BIT];
        go_clr = wr_i && (addr_i == `HSR_ADDR_CTRL) && !wdata_i[`HSR_CTRL_GO_BIT];
        cur_slot = s_reg.slot_reg[s_reg.slot_idx];
        cur_repeat = slot_repeat_count(s_reg.repeat_reg, s_reg.slot_idx);
        // Idle and waveform slots end alike
        effect_fin = s_reg.waiting ? tmr_done : play_done_i;
    end

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        tmr_start = 1'b0;
        tmr_abort = 1'b0;
        rep_clear = 1'b0;
        rep_step = 1'b0;

        // Register writes
        if (wr_i) begin
            if (slot_hit) begin
                s_next.slot_reg[slot_off[2:0]] = wdata_i;
            end
            if (addr_i == `HSR_ADDR_REPEAT_LO) begin
                s_next.repeat_reg[0] = wdata_i;
            end
            if (addr_i == `HSR_ADDR_REPEAT_HI) begin
                s_next.repeat_reg[1] = wdata_i;
            end
        end

        // Register reads, data valid in the following cycle only
        if (rd_i) begin
            if (slot_hit) begin
                s_next.rdata = s_reg.slot_reg[slot_off[2:0]];
            end else if (addr_i == `HSR_ADDR_CTRL) begin
                s_next.rdata = {7'h00, s_reg.busy};
            end else if (addr_i == `HSR_ADDR_REPEAT_LO) begin
                s_next.rdata = s_reg.repeat_reg[0];
            end else if (addr_i == `HSR_ADDR_REPEAT_HI) begin
                s_next.rdata = s_reg.repeat_reg[1];
            end else begin
                s_next.rdata = 8'h00;
            end
        end

        unique case (s_reg.state)
            HSR_IDLE: begin
                if (go_set) begin
                    s_next.slot_idx = 3'h0;
                    s_next.busy = 1'b1;
                    s_next.state = HSR_FETCH;
                    rep_clear = 1'b1;
                end
            end

            HSR_FETCH: begin
                if (!cur_slot.delay_flag && cur_slot.effect_value == 7'h00) begin
                    s_next.busy = 1'b0;
                    s_next.state = HSR_IDLE;
                end else if (cur_slot.delay_flag) begin
                    tmr_start = 1'b1;
                    s_next.waiting = 1'b1;
                    s_next.state = HSR_PLAY;
                end else begin
                    s_next.play.req = 1'b1;
                    s_next.play.effect_id = cur_slot.effect_value;
                    s_next.state = HSR_PLAY;
                end
            end

            HSR_PLAY: begin
                if (effect_fin) begin
                    s_next.play.req = 1'b0;
                    s_next.waiting = 1'b0;
                    if (rep_last) begin
                        s_next.state = HSR_NEXT;
                    end else begin
                        rep_step = 1'b1;
                        s_next.state = HSR_FETCH;
                    end
                end
            end

            HSR_NEXT: begin
                if (s_reg.slot_idx == `HSR_SLOT_LAST_IDX) begin
                    s_next.busy = 1'b0;
                    s_next.state = HSR_IDLE;
                end else begin
                    s_next.slot_idx = s_reg.slot_idx + 3'h1;
                    s_next.state = HSR_FETCH;
                    rep_clear = 1'b1;
                end
            end
        endcase

        // Clearing go while running aborts the sequence
        if (go_clr && s_reg.busy) begin
            tmr_abort = 1'b1;
            s_next.busy = 1'b0;
            s_next.waiting = 1'b0;
            s_next.play.req = 1'b0;
            s_next.state = HSR_IDLE;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_reg <= '0;
            s_reg.state <= HSR_IDLE;
            s_reg.repeat_reg[0] <= `HSR_REPEAT_RESET;
            s_reg.repeat_reg[1] <= `HSR_REPEAT_RESET;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = s_reg.rdata;
    assign play_o = s_reg.play;
    assign busy_o = s_reg.busy;
    assign waiting_o = s_reg.waiting;
    assign slot_idx_o = s_reg.slot_idx;

endmodule : hsr_sequencer
`default_nettype wire

// ===== pkg/hsr_defines.svh
// Offsets, field positions, reset values and timing counts of the slot repeat sequencer
`ifndef HSR_DEFINES_SVH
`define HSR_DEFINES_SVH

// Register offsets
`define HSR_ADDR_CTRL 8'h0C
`define HSR_ADDR_SLOT_FIRST 8'h0F
`define HSR_ADDR_SLOT_LAST 8'h16
`define HSR_ADDR_REPEAT_LO 8'h17
`define HSR_ADDR_REPEAT_HI 8'h18

// Field positions
`define HSR_CTRL_GO_BIT 0
`define HSR_SLOT_DELAY_BIT 7
`define HSR_REPEAT_W 2

// Reset values
`define HSR_REPEAT_RESET 8'h00
`define HSR_SLOT_RESET 8'h00

// Slot count and last slot index
`define HSR_SLOT_COUNT 8
`define HSR_SLOT_LAST_IDX 3'h7

// Idle period unit and the clock rate that turns it into cycles
`define HSR_WAIT_UNIT_MS 10
`define HSR_CLK_KHZ 125000
`define HSR_WAIT_UNIT_CYCLES (`HSR_WAIT_UNIT_MS * `HSR_CLK_KHZ)
`define HSR_TICK_W 21

`endif

// ===== pkg/hsr_pkg.sv
// Types shared by the slot repeat sequencer modules
package hsr_pkg;

    // Sequencer states, Gray coded along idle-fetch-play-next
    typedef enum logic [1:0] {
        HSR_IDLE = 2'h0,
        HSR_FETCH = 2'h1,
        HSR_PLAY = 2'h3,
        HSR_NEXT = 2'h2
    } hsr_state_t;

    // One sequence slot: idle flag plus 7-bit value
    typedef struct packed {
        logic delay_flag;
        logic [6:0] effect_value;
    } hsr_slot_t;

    // Request to the waveform playback engine
    typedef struct packed {
        logic req;
        logic [6:0] effect_id;
    } hsr_play_t;

    // State of the idle-period timer
    typedef struct packed {
        logic active;
        logic done;
        logic [6:0] units_left;
        logic [20:0] tick;
    } hsr_tmr_t;

    // State of the per-slot repeat counter
    typedef struct packed {
        logic [1:0] cnt;
    } hsr_rep_t;

    // State of the sequencer top
    typedef struct packed {
        hsr_state_t state;
        logic busy;
        logic waiting;
        logic [2:0] slot_idx;
        hsr_play_t play;
        logic [7:0] rdata;
        logic [1:0][7:0] repeat_reg;
        hsr_slot_t [7:0] slot_reg;
    } hsr_seq_t;

endpackage : hsr_pkg
